// >>> core/rim_masks.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// R1 - top mask bit 0 gates register-reset interrupt
// R2 - host writes to reset-reg mask ignored
// R3 - switcher bit 7 masks sw1 pg fall
// R4 - switcher bit 6 masks sw1 pg rise
// R5 - switcher bit 3 masks sw0 pg fall
// R6 - switcher bit 2 masks sw0 pg rise
// R7 - switcher bit 4 masks sw1 overcurrent
// R8 - switcher bit 0 masks sw0 overcurrent
// R9 - raw status unaffected by any mask
// R10 - linear mask layout mirrors switcher, 5,1 reserved
// R11 - linear mask 1 suppresses, 0 allows
// R12 - masks load from otp; irq on unmasked flag
module rim_masks
   import rim_pkg::*;
(
   // clock, reset, clock enable
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // register access from the serial interface engine
   input wire rim_reg_req_t req_i,
   output logic [7:0] rdata_o,
   output logic rvalid_o,
   // one-time-programmable defaults, taken while otp_load_i is high
   input wire logic otp_load_i,
   input wire rim_otp_t otp_i,
   // raw regulator status
   input wire rim_raw_t sw0_raw_i,
   input wire rim_raw_t sw1_raw_i,
   input wire rim_raw_t lin0_raw_i,
   input wire rim_raw_t lin1_raw_i,
   // register-reset event from the reset sequencer
   input wire logic reset_reg_evt_i,
   // pending flags from the flag registers
   input wire rim_flags_t flags_i,
   // event requests towards the flag registers
   output rim_evt_t sw0_evt_o,
   output rim_evt_t sw1_evt_o,
   output rim_evt_t lin0_evt_o,
   output rim_evt_t lin1_evt_o,
   output logic reset_reg_evt_o,
   // raw status copies and the interrupt line
   output rim_raw_t sw0_raw_o,
   output rim_raw_t sw1_raw_o,
   output rim_raw_t lin0_raw_o,
   output rim_raw_t lin1_raw_o,
   output logic irq_o
);

   logic [7:0] top_b_reg; // bit 0 otp-only, 7:1 plain storage
   logic [7:0] sw_mask_reg; // switcher masks
   logic [7:0] lin_mask_reg; // linear regulator masks
   logic [7:0] rdata_reg; // registered read data
   logic rvalid_reg; // read answer strobe
   logic reset_evt_reg; // gated register-reset event
   logic irq_reg; // interrupt output flop
   logic irq_next; // interrupt next value

   // unmasked pg flag: the flag is one bit for both directions, so it
   // only stays hidden when both direction masks are set
   function automatic logic pg_live(input logic flag, input logic [7:0] m,
                                    input int fall_b, input int rise_b);
      pg_live = flag & ~(m[fall_b] & m[rise_b]);
   endfunction

   // keep only the writable bits of a paired mask register
   function automatic logic [7:0] pair_bits(input logic [7:0] v);
      pair_bits = v & RIM_PAIR_MASK_BITS;
   endfunction

   // top-level second mask register
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         top_b_reg <= RIM_TOP_MASK_B_RST;
      end else if (ce_i) begin
         if (otp_load_i) begin
            top_b_reg[RIM_RESET_REG_MASK_BIT] <= otp_i.reset_reg_mask; // R12
         end
         // only the reserved storage bits take a host write
         if (req_i.wr && req_i.addr == RIM_TOP_MASK_B_OFS) begin
            top_b_reg[7:1] <= req_i.wdata[7:1]; // R2
         end
      end
   end

   // switcher mask register; a host write beats the otp load
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sw_mask_reg <= RIM_SW_MASK_RST;
      end else if (ce_i) begin
         if (req_i.wr && req_i.addr == RIM_SW_MASK_OFS) begin
            sw_mask_reg <= pair_bits(req_i.wdata);
         end else if (otp_load_i) begin
            sw_mask_reg <= pair_bits(otp_i.sw_mask); // R12
         end
      end
   end

   // linear mask register, same layout as the switcher one
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lin_mask_reg <= RIM_LIN_MASK_RST;
      end else if (ce_i) begin
         if (req_i.wr && req_i.addr == RIM_LIN_MASK_OFS) begin
            lin_mask_reg <= pair_bits(req_i.wdata); // R10
         end else if (otp_load_i) begin
            lin_mask_reg <= pair_bits(otp_i.lin_mask); // R12
         end
      end
   end

   // read port: one cycle latency, unmapped offsets read zero
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_reg <= RIM_RDATA_RST;
         rvalid_reg <= 1'b0;
      end else if (ce_i) begin
         rvalid_reg <= req_i.rd;
         if (req_i.rd) begin
            case (req_i.addr)
               RIM_TOP_MASK_B_OFS: rdata_reg <= top_b_reg;
               RIM_SW_MASK_OFS: rdata_reg <= sw_mask_reg;
               RIM_LIN_MASK_OFS: rdata_reg <= lin_mask_reg; // R10
               default: rdata_reg <= RIM_RDATA_RST;
            endcase
         end
      end
   end

   // register-reset event gated by its mask bit
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reset_evt_reg <= 1'b0;
      end else if (ce_i) begin
         reset_evt_reg <= reset_reg_evt_i &
                          ~top_b_reg[RIM_RESET_REG_MASK_BIT]; // R1
      end
   end

   // interrupt is a level: high while any pending flag is unmasked;
   // a mask set later hides an already pending flag as well
   always_comb begin
      irq_next =
         (flags_i.reset_reg & ~top_b_reg[RIM_RESET_REG_MASK_BIT]) | // R1
         pg_live(flags_i.sw1_pg, sw_mask_reg,
                 RIM_R1_PG_FALL_BIT, RIM_R1_PG_RISE_BIT) | // R3 R4
         pg_live(flags_i.sw0_pg, sw_mask_reg,
                 RIM_R0_PG_FALL_BIT, RIM_R0_PG_RISE_BIT) | // R5 R6
         (flags_i.sw1_overcurrent & ~sw_mask_reg[RIM_R1_OVERCURRENT_BIT]) |
         (flags_i.sw0_overcurrent & ~sw_mask_reg[RIM_R0_OVERCURRENT_BIT]) |
         pg_live(flags_i.lin1_pg, lin_mask_reg,
                 RIM_R1_PG_FALL_BIT, RIM_R1_PG_RISE_BIT) |
         pg_live(flags_i.lin0_pg, lin_mask_reg,
                 RIM_R0_PG_FALL_BIT, RIM_R0_PG_RISE_BIT) |
         (flags_i.lin1_overcurrent &
          ~lin_mask_reg[RIM_R1_OVERCURRENT_BIT]) | // R11
         (flags_i.lin0_overcurrent &
          ~lin_mask_reg[RIM_R0_OVERCURRENT_BIT]); // R12
   end

   // interrupt output flop
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_reg <= 1'b0;
      end else if (ce_i) begin
         irq_reg <= irq_next; // R12
      end
   end

   // first switcher
   rim_event_gate u_sw0 (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .raw_i(sw0_raw_i),
      .pg_fall_mask_i(sw_mask_reg[RIM_R0_PG_FALL_BIT]),
      .pg_rise_mask_i(sw_mask_reg[RIM_R0_PG_RISE_BIT]),
      .overcurrent_mask_i(sw_mask_reg[RIM_R0_OVERCURRENT_BIT]),
      .evt_o(sw0_evt_o),
      .raw_o(sw0_raw_o)
   );

   // second switcher
   rim_event_gate u_sw1 (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .raw_i(sw1_raw_i),
      .pg_fall_mask_i(sw_mask_reg[RIM_R1_PG_FALL_BIT]),
      .pg_rise_mask_i(sw_mask_reg[RIM_R1_PG_RISE_BIT]),
      .overcurrent_mask_i(sw_mask_reg[RIM_R1_OVERCURRENT_BIT]),
      .evt_o(sw1_evt_o),
      .raw_o(sw1_raw_o)
   );

   // first linear regulator
   rim_event_gate u_lin0 (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .raw_i(lin0_raw_i),
      .pg_fall_mask_i(lin_mask_reg[RIM_R0_PG_FALL_BIT]),
      .pg_rise_mask_i(lin_mask_reg[RIM_R0_PG_RISE_BIT]),
      .overcurrent_mask_i(lin_mask_reg[RIM_R0_OVERCURRENT_BIT]),
      .evt_o(lin0_evt_o),
      .raw_o(lin0_raw_o)
   );

   // second linear regulator
   rim_event_gate u_lin1 (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .raw_i(lin1_raw_i),
      .pg_fall_mask_i(lin_mask_reg[RIM_R1_PG_FALL_BIT]),
      .pg_rise_mask_i(lin_mask_reg[RIM_R1_PG_RISE_BIT]),
      .overcurrent_mask_i(lin_mask_reg[RIM_R1_OVERCURRENT_BIT]),
      .evt_o(lin1_evt_o),
      .raw_o(lin1_raw_o)
   );

   assign rdata_o = rdata_reg;
   assign rvalid_o = rvalid_reg;
   assign reset_reg_evt_o = reset_evt_reg;
   assign irq_o = irq_reg;

endmodule
`default_nettype wire

// >>> core/rim_pkg.sv
package rim_pkg;

   // register offsets on the internal serial-register port
   localparam logic [7:0] RIM_TOP_MASK_B_OFS = 8'h21;
   localparam logic [7:0] RIM_SW_MASK_OFS = 8'h22;
   localparam logic [7:0] RIM_LIN_MASK_OFS = 8'h23;

   // field positions; the first is in the top mask register, the rest are shared by the switcher and linear mask registers
   localparam int RIM_RESET_REG_MASK_BIT = 0;
   localparam int RIM_R1_PG_FALL_BIT = 7;
   localparam int RIM_R1_PG_RISE_BIT = 6;
   localparam int RIM_R1_OVERCURRENT_BIT = 4;
   localparam int RIM_R0_PG_FALL_BIT = 3;
   localparam int RIM_R0_PG_RISE_BIT = 2;
   localparam int RIM_R0_OVERCURRENT_BIT = 0;

   // bits that take a host write in the mask registers; the other pair-register bits read zero
   localparam logic [7:0] RIM_TOP_B_RW_BITS = 8'hfe;
   localparam logic [7:0] RIM_PAIR_MASK_BITS = 8'hdd;

   // values after reset, before the one-time-programmable load lands
   localparam logic [7:0] RIM_TOP_MASK_B_RST = 8'h00;
   localparam logic [7:0] RIM_SW_MASK_RST = 8'h00;
   localparam logic [7:0] RIM_LIN_MASK_RST = 8'h00;
   localparam logic [7:0] RIM_RDATA_RST = 8'h00;

   // one register access from the serial interface engine
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rim_reg_req_t;

   // raw status of one regulator
   typedef struct packed {
      logic pg_invalid;
      logic overcurrent;
   } rim_raw_t;

   // event requests of one regulator towards the flag registers
   typedef struct packed {
      logic pg_event;
      logic overcurrent_event;
   } rim_evt_t;

   // defaults held in one-time-programmable memory
   typedef struct packed {
      logic reset_reg_mask;
      logic [7:0] sw_mask;
      logic [7:0] lin_mask;
   } rim_otp_t;

   // pending flags held in the flag registers outside this block
   typedef struct packed {
      logic reset_reg;
      logic sw1_pg;
      logic sw1_overcurrent;
      logic sw0_pg;
      logic sw0_overcurrent;
      logic lin1_pg;
      logic lin1_overcurrent;
      logic lin0_pg;
      logic lin0_overcurrent;
   } rim_flags_t;

endpackage

// >>> core/rim_event_gate.sv
`timescale 1ns/1ps
`default_nettype none
// edge detection and masking for one regulator's events
module rim_event_gate
   import rim_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // raw status and masks
   input wire rim_raw_t raw_i,
   input wire logic pg_fall_mask_i,
   input wire logic pg_rise_mask_i,
   input wire logic overcurrent_mask_i,
   // gated event requests, raw status copy
   output rim_evt_t evt_o,
   output rim_raw_t raw_o
);

   rim_raw_t prev_reg; // last sampled raw status
   rim_evt_t evt_reg; // registered event requests
   rim_raw_t raw_reg; // raw copy, never touched by masks

   // raw status is followed whatever the masks hold
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prev_reg <= '0;
         raw_reg <= '0;
      end else if (ce_i) begin
         prev_reg <= raw_i;
         raw_reg <= raw_i; // R9
      end
   end

   // pg_invalid high means power-good became invalid; a set mask bit
   // only stops the event request, so one edge can never be lost twice
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         evt_reg <= '0;
      end else if (ce_i) begin
         evt_reg.pg_event <=
            (raw_i.pg_invalid & ~prev_reg.pg_invalid & ~pg_fall_mask_i) |
            (~raw_i.pg_invalid & prev_reg.pg_invalid & ~pg_rise_mask_i);
         // R3 R4 R5 R6 R11
         evt_reg.overcurrent_event <=
            raw_i.overcurrent & ~prev_reg.overcurrent & ~overcurrent_mask_i;
         // R7 R8 R11
      end
   end

   assign evt_o = evt_reg;
   assign raw_o = raw_reg;

endmodule
`default_nettype wire

// >>> verif/rim_masks_properties.sv
`timescale 1ns/1ps
`default_nettype none
// port-level watcher of the mask block
module rim_masks_properties
   import rim_pkg::*;
(
   // clock, reset, clock enable
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // register port
   input wire rim_reg_req_t req_i,
   input wire logic [7:0] rdata_o,
   input wire logic rvalid_o,
   // defaults, raw status, flags
   input wire logic otp_load_i,
   input wire rim_otp_t otp_i,
   input wire rim_raw_t sw0_raw_i,
   input wire rim_raw_t sw1_raw_i,
   input wire rim_raw_t lin1_raw_i,
   input wire logic reset_reg_evt_i,
   input wire rim_flags_t flags_i,
   // results
   input wire rim_evt_t sw0_evt_o,
   input wire rim_evt_t sw1_evt_o,
   input wire rim_evt_t lin1_evt_o,
   input wire logic reset_reg_evt_o,
   input wire rim_raw_t sw1_raw_o,
   input wire logic irq_o
);
   logic top0_reg; // shadow of the reset-event mask
   logic [6:0] top_hi_reg; // plain storage bits of 0x21
   logic [7:0] sw_reg, lin_reg, rd_exp;
   logic ce_q_reg, live_reg, ce1, ce2, irq_exp;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // edge detection only holds after two enabled edges in a row; the
   // edge that releases reset still sees reset low inside the block,
   // so its results are not held against the inputs of that edge
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ce_q_reg <= 1'b0;
         live_reg <= 1'b0;
      end else begin
         ce_q_reg <= ce_i;
         live_reg <= 1'b1;
      end
   end
   // mask shadow; a host write wins over a load in the same cycle
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         top0_reg <= RIM_TOP_MASK_B_RST[0];
         top_hi_reg <= RIM_TOP_MASK_B_RST[7:1];
         sw_reg <= RIM_SW_MASK_RST;
         lin_reg <= RIM_LIN_MASK_RST;
      end else if (ce_i) begin
         if (otp_load_i) begin
            top0_reg <= otp_i.reset_reg_mask;
            sw_reg <= otp_i.sw_mask & RIM_PAIR_MASK_BITS;
            lin_reg <= otp_i.lin_mask & RIM_PAIR_MASK_BITS;
         end
         if (req_i.wr && req_i.addr == RIM_TOP_MASK_B_OFS) begin
            top_hi_reg <= req_i.wdata[7:1];
         end
         if (req_i.wr && req_i.addr == RIM_SW_MASK_OFS) begin
            sw_reg <= req_i.wdata & RIM_PAIR_MASK_BITS;
         end
         if (req_i.wr && req_i.addr == RIM_LIN_MASK_OFS) begin
            lin_reg <= req_i.wdata & RIM_PAIR_MASK_BITS;
         end
      end
   end
   // pending flags of one register pair; pg needs both masks to hide
   function automatic logic pend(input logic [7:0] m, input logic [3:0] f);
      return f[3] & ~&m[7:6] | f[2] & ~m[4] |
         f[1] & ~&m[3:2] | f[0] & ~m[0];
   endfunction
   assign ce1 = ce_i && live_reg;
   assign ce2 = ce_i && ce_q_reg;
   assign irq_exp = flags_i.reset_reg & ~top0_reg |
      pend(sw_reg, flags_i[7:4]) | pend(lin_reg, flags_i[3:0]);
   assign rd_exp =
      (req_i.addr == RIM_TOP_MASK_B_OFS) ? {top_hi_reg, top0_reg} :
      (req_i.addr == RIM_SW_MASK_OFS) ? sw_reg :
      (req_i.addr == RIM_LIN_MASK_OFS) ? lin_reg : 8'h00;
   a_read_answer: assert property (ce_i && req_i.rd |=>
      rvalid_o && rdata_o == $past(rd_exp)) else $error("read answer wrong");
   a_reset_gate: assert property (ce1 |=> reset_reg_evt_o ==
      ($past(reset_reg_evt_i) && !$past(top0_reg))) else $error("reset gate");
   a_sw1_fall_gate: assert property (ce2 &&
      $rose(sw1_raw_i.pg_invalid) |=>
      sw1_evt_o.pg_event == !$past(sw_reg[7])) else $error("sw1 fall gate");
   a_sw1_rise_gate: assert property (ce2 &&
      $fell(sw1_raw_i.pg_invalid) |=>
      sw1_evt_o.pg_event == !$past(sw_reg[6])) else $error("sw1 rise gate");
   a_sw0_fall_gate: assert property (ce2 &&
      $rose(sw0_raw_i.pg_invalid) |=>
      sw0_evt_o.pg_event == !$past(sw_reg[3])) else $error("sw0 fall gate");
   a_sw1_oc_gate: assert property (ce2 &&
      $rose(sw1_raw_i.overcurrent) |=>
      sw1_evt_o.overcurrent_event == !$past(sw_reg[4])) else $error("sw1 oc");
   a_sw0_oc_gate: assert property (ce2 &&
      $rose(sw0_raw_i.overcurrent) |=>
      sw0_evt_o.overcurrent_event == !$past(sw_reg[0])) else $error("sw0 oc");
   a_lin1_fall_gate: assert property (ce2 &&
      $rose(lin1_raw_i.pg_invalid) |=>
      lin1_evt_o.pg_event == !$past(lin_reg[7])) else $error("lin1 fall");
   a_raw_copy: assert property (ce1 |=> sw1_raw_o == $past(sw1_raw_i))
      else $error("raw copy wrong");
   a_irq_level: assert property (ce1 |=> irq_o == $past(irq_exp))
      else $error("irq level wrong");
   // a low clock enable must hold rdata_o, rvalid_o, irq_o and sw1_evt_o where they stand
   a_ce_freeze: assert property (!ce_i |=> $stable(rdata_o) &&
      $stable(rvalid_o) && $stable(irq_o) && $stable(sw1_evt_o))
      else $error("clock enable freeze broken");
   c_read: cover property (ce_i && req_i.rd);
   c_reset_evt: cover property (reset_reg_evt_o);
   c_irq: cover property (irq_o);
   c_frozen_write: cover property (!ce_i && req_i.wr);
endmodule
bind rim_masks rim_masks_properties chk (.*);
`default_nettype wire

// >>> verif/rim_host.sv
`timescale 1ns/1ps
`default_nettype none
// host side of the register port, one access at a time
module rim_host
   import rim_pkg::*;
(
   // clock
   input wire logic clk_i,
   // access towards the masks
   output var rim_reg_req_t req_o
);
   // idle at time zero
   initial begin
      req_o = '0;
   end
   // strobe stands one taken edge; idle fields show the inverse after
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      req_o <= '{1'b1, 1'b0, a, d};
      @(posedge clk_i);
      req_o <= '{1'b0, 1'b0, ~a, ~d};
   endtask
   // read strobe; answer is watched by the bench
   task automatic rd(input logic [7:0] a);
      @(posedge clk_i);
      req_o <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk_i);
      req_o <= '{1'b0, 1'b0, ~a, 8'hff};
   endtask
endmodule
`default_nettype wire

// >>> verif/rim_masks_test.sv
`timescale 1ns/1ps
`default_nettype none
// otp loads, host writes and random event bursts against a mirror
module rim_masks_test
   import rim_pkg::*;
;
   typedef struct {int due; bit k; logic [17:0] v;} rim_note_t;
   logic clk_i, rst_n_i, ce_i, otp_load_i, rre, cre, top0;
   rim_otp_t otp;
   logic [7:0] rv, cur, prev, sw, lin; // raw order sw1 sw0 lin1 lin0
   logic [8:0] fl, cfl;
   logic [6:0] th;
   logic [31:0] r, seed;
   int nc, i, it, mismatches, comparisons;
   rim_note_t q[$], n; // expected results, oldest first
   wire rim_reg_req_t req;
   wire logic [7:0] rdata, ev, ro;
   wire logic rvalid, rre_o, irq;
   rim_host host (.clk_i(clk_i), .req_o(req));
   rim_masks DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
      .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid),
      .otp_load_i(otp_load_i), .otp_i(otp), .sw0_raw_i(rv[5:4]),
      .sw1_raw_i(rv[7:6]), .lin0_raw_i(rv[1:0]), .lin1_raw_i(rv[3:2]),
      .reset_reg_evt_i(rre), .flags_i(fl), .sw0_evt_o(ev[5:4]),
      .sw1_evt_o(ev[7:6]), .lin0_evt_o(ev[1:0]), .lin1_evt_o(ev[3:2]),
      .reset_reg_evt_o(rre_o), .sw0_raw_o(ro[5:4]), .sw1_raw_o(ro[7:6]),
      .lin0_raw_o(ro[1:0]), .lin1_raw_o(ro[3:2]), .irq_o(irq));
   // mask nibble m: fall, rise, unused, overcurrent
   function automatic logic [1:0] g(input logic [1:0] c, p, logic [3:0] m);
      return {c[1] & ~p[1] & ~m[3] | ~c[1] & p[1] & ~m[2],
         c[0] & ~p[0] & ~m[0]};
   endfunction
   function automatic logic fi(input logic [1:0] f, input logic [3:0] m);
      return f[1] & ~&m[3:2] | f[0] & ~m[0];
   endfunction
   function automatic logic [17:0] expv();
      return {cfl[8] & ~top0 | fi(cfl[7:6], sw[7:4]) |
         fi(cfl[5:4], sw[3:0]) | fi(cfl[3:2], lin[7:4]) |
         fi(cfl[1:0], lin[3:0]), cre & ~top0,
         g(cur[7:6], prev[7:6], sw[7:4]), g(cur[5:4], prev[5:4], sw[3:0]),
         g(cur[3:2], prev[3:2], lin[7:4]),
         g(cur[1:0], prev[1:0], lin[3:0]), cur};
   endfunction
   task automatic check(input string nm, input logic [17:0] s, e);
      comparisons++;
      if (s !== e) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", nm, e, s);
      end
   endtask
   // a note is due at the falling edge after the edge that samples it
   task automatic note(input bit k, input logic [17:0] v);
      q.push_back('{nc, k, v});
   endtask
   task automatic rd(input logic [7:0] a, e);
      host.rd(a);
      note(1'b0, {9'h000, 1'b1, e});
   endtask
   // all three masks plus one unmapped place
   task automatic rdall();
      rd(RIM_TOP_MASK_B_OFS, {th, top0});
      rd(RIM_SW_MASK_OFS, sw);
      rd(RIM_LIN_MASK_OFS, lin);
      rd(8'h24, 8'h00);
   endtask
   task automatic conclude();
      // notes still queued were never answered
      mismatches += q.size();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   // run needs about 300 cycles; cut off far beyond that
   initial begin
      #20000;
      mismatches++;
      conclude();
   end
   // monitor: settled outputs against the oldest due notes
   always @(negedge clk_i) begin
      while (q.size() > 0 && q[0].due == nc) begin
         n = q.pop_front();
         if (n.k) begin
            check("irq", 18'({irq, rre_o}), 18'(n.v[17:16]));
            check("events", 18'(ev), 18'(n.v[15:8]));
            check("raw", 18'(ro), 18'(n.v[7:0]));
         end else begin
            check("read", {9'h000, rvalid, rdata}, n.v);
         end
      end
      nc++;
   end
   initial begin
      {rst_n_i, otp_load_i, rre, otp, rv, fl, cur, cre, cfl} = '0;
      {nc, mismatches, comparisons} = '0;
      ce_i = 1'b1;
      seed = 32'hb79de5ad;
      {th, top0} = RIM_TOP_MASK_B_RST;
      sw = RIM_SW_MASK_RST;
      lin = RIM_LIN_MASK_RST;
      repeat (12) @(posedge clk_i);
      rst_n_i <= 1'b1;
      rdall();
      for (it = 0; it < 4; it++) begin
         r = $random(seed);
         @(posedge clk_i);
         otp <= r[16:0];
         otp_load_i <= 1'b1;
         @(posedge clk_i);
         otp_load_i <= 1'b0;
         top0 = r[16];
         sw = r[15:8] & RIM_PAIR_MASK_BITS;
         lin = r[7:0] & RIM_PAIR_MASK_BITS;
         r = $random(seed);
         // bit 0 is written opposite to the loaded value and must stay
         host.wr(RIM_TOP_MASK_B_OFS, {r[7:1], ~top0});
         th = r[7:1];
         host.wr(RIM_SW_MASK_OFS, r[15:8]);
         sw = r[15:8] & RIM_PAIR_MASK_BITS;
         host.wr(RIM_LIN_MASK_OFS, r[23:16]);
         lin = r[23:16] & RIM_PAIR_MASK_BITS;
         host.wr(8'h24, r[31:24]);
         rdall();
         for (i = 0; i <= 40; i++) begin
            @(posedge clk_i);
            if (i > 0) note(1'b1, expv());
            prev = cur;
            r = $random(seed);
            {cfl, cre, cur} = r[17:0];
            rv <= cur;
            rre <= cre;
            fl <= cfl;
         end
      end
      // a write while the clock enable is low must leave the masks alone
      @(posedge clk_i);
      ce_i <= 1'b0;
      host.wr(RIM_SW_MASK_OFS, ~sw);
      ce_i <= 1'b1;
      rdall();
      // reset in mid-run brings every mask back to its reset value
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      {th, top0} = RIM_TOP_MASK_B_RST;
      sw = RIM_SW_MASK_RST;
      lin = RIM_LIN_MASK_RST;
      rdall();
      repeat (3) @(posedge clk_i);
      conclude();
   end
endmodule
`default_nettype wire
